// *** core/mirq_pkg.sv ***
// Shared constants and types for the mode and interrupt configuration bank
package mirq_pkg;
	// Device register offsets on the parallel bus
	localparam logic [7:0] MODE_OFS = 8'h0C;
	localparam logic [7:0] ICFG_OFS = 8'h10;
	localparam logic [7:0] IEN_LO_OFS = 8'h14;
	localparam logic [7:0] IEN_HI_OFS = 8'h16;
	localparam logic [7:0] IRQ_LO_OFS = 8'h18;
	localparam logic [7:0] IRQ_HI_OFS = 8'h1A;
	// Mode register bit positions
	localparam int MB_CLK_ON = 7;
	localparam int MB_WAKEUP = 6;
	localparam int MB_SUSPEND = 5;
	localparam int MB_SRESET = 4;
	localparam int MB_GIRQ = 3;
	localparam int MB_WAKE_CS = 2;
	localparam int MB_POWER_OFF_IN_SLEEP = 1;
	localparam int MB_PULLUP = 0;
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [7:0] MODE_BRST_KEEP = 8'h0B;
	// Interrupt output configuration fields
	localparam int IC_CTRL_LSB = 6;
	localparam int IC_IN_LSB = 4;
	localparam int IC_OUT_LSB = 2;
	localparam int IC_PULSE = 1;
	localparam int IC_POL = 0;
	localparam logic [7:0] ICFG_RST = 8'hFC;
	localparam logic [7:0] ICFG_BRST_KEEP = 8'h03;
	localparam logic [7:0] ICFG_BRST_SET = 8'hFC;
	// Per-source enables and pending flags
	localparam logic [31:0] IEN_RST = 32'h0000_0000;
	localparam logic [31:0] IEN_BRST_KEEP = 32'h0000_0001;
	localparam logic [31:0] IEN_WMASK = 32'h03FF_FD7F;
	localparam logic [4:0] HS_IDX_BASE = 5'h0A;
	// Handshake kinds from the serial engine
	localparam logic [1:0] HS_ACK = 2'h0;
	localparam logic [1:0] HS_NAK = 2'h1;
	localparam logic [1:0] HS_STALL = 2'h2;
	localparam logic [1:0] HS_NYET = 2'h3;
	// Timing
	localparam int CLK_NS = 20;
	localparam int SUSP_CLK_STOP_US = 2000;
	localparam int RES_DELAY_US = 5000;
	localparam int RES_DRIVE_US = 10000;
	localparam int IRQ_PULSE_NS = 60;
	localparam int SUSP_CLK_STOP_CYC = SUSP_CLK_STOP_US * 1000 / CLK_NS;
	localparam int RES_DELAY_CYC = RES_DELAY_US * 1000 / CLK_NS;
	localparam int RES_DRIVE_CYC = RES_DRIVE_US * 1000 / CLK_NS;
	localparam int IRQ_PULSE_CYC = (IRQ_PULSE_NS + CLK_NS - 1) / CLK_NS;
	localparam int TMR_W = 20;
	// Controller APB register offsets
	localparam logic [7:0] HC_TARGET_OFS = 8'h00;
	localparam logic [7:0] HC_WDATA_OFS = 8'h04;
	localparam logic [7:0] HC_CMD_OFS = 8'h08;
	localparam logic [7:0] HC_STATUS_OFS = 8'h0C;
	localparam logic [7:0] HC_RDATA_OFS = 8'h10;
	localparam int HC_CMD_WR = 0;
	localparam int HC_CMD_RD = 1;
	// States
	typedef enum logic [1:0] {RES_IDLE, RES_WAIT, RES_DRIVE} mirq_res_type;
	typedef enum logic [1:0] {HST_IDLE, HST_WR, HST_RD, HST_CAP} mirq_hst_type;
endpackage

// *** core/mirq_if.sv ***
// Parallel register bus between controller and device
`timescale 1ns/10ps
interface mirq_if;
	logic cs_n;
	logic wr_n;
	logic rd_n;
	logic [7:0] addr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	modport dev (input cs_n, input wr_n, input rd_n, input addr,
		input wdata, output rdata);
	modport host (output cs_n, output wr_n, output rd_n, output addr,
		output wdata, input rdata);
endinterface

// *** core/mirq_dev.sv ***
// Device end: mode and interrupt configuration registers with their effects
`timescale 1ns/10ps
// Notes on behaviour
// - Mode register at 0x0C, upper byte ignored
// - Mode clears on reset; bus reset partly
// - Clocks stop 2 ms into suspend unless on
// - Wake-up write: 5 ms wait, 10 ms resume
// - Suspend write enters suspend mode
// - Soft reset write acts as hardware reset
// - Global gate passes or blocks all interrupts
// - Low select requests wake-up when enabled
// - Power-off bit drives suspend output high while suspended
// - Pull-up bit connects the D+ pull-up
// - Interrupt configuration register at 0x10
// - Pulse select: level or 60 ns pulse
// - Polarity bit sets active level or edge
// - Selector fields at 7:6, 5:4, 3:2, reset 3
// - Handshakes raise interrupts per endpoint class
// - Endpoint 0 handshake selection table
// - Data IN handshake selection table
// - Data OUT handshake selection table
// - First NAK only after a prior ACK
// - Bus reset clears enables but bus-reset one
module mirq_dev #(
	parameter int CLK_STOP_CYC = mirq_pkg::SUSP_CLK_STOP_CYC,
	parameter int RES_DELAY_CYC = mirq_pkg::RES_DELAY_CYC,
	parameter int RES_DRIVE_CYC = mirq_pkg::RES_DRIVE_CYC
) (
	// Clock, reset, enable
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	input wire logic clk_en_i,
	// Register bus
	mirq_if.dev bus,
	// Serial engine events
	input wire logic usb_bus_reset_i,
	input wire logic usb_resume_i,
	input wire logic hs_valid_i,
	input wire logic [1:0] hs_kind_i,
	input wire logic hs_dir_in_i,
	input wire logic [2:0] hs_ep_i,
	input wire logic [8:0] evt_src_i,
	// Controls and status
	output logic irq_o,
	output logic suspended_o,
	output logic suspend_o,
	output logic clk_stop_o,
	output logic resume_drive_o,
	output logic pullup_resistor_pin_o,
	output logic wake_req_o
);
	import mirq_pkg::*;

	typedef struct packed {
		logic [7:0] mode;
		logic [7:0] icfg;
		logic [31:0] ien;
		logic [31:0] pend;
		logic [31:0] nak_first;
		logic susp;
		logic clk_stop;
		mirq_res_type res;
		logic [TMR_W-1:0] tmr;
		logic [TMR_W-1:0] ctmr;
		logic [1:0] pcnt;
		logic [15:0] rdata;
	} mirq_dev_st_type;

	localparam mirq_dev_st_type DEV_RST = '{mode: MODE_RST, icfg: ICFG_RST,
		ien: IEN_RST, res: RES_IDLE, default: '0};

	// Handshake qualification by selector value
	function automatic logic hs_raise(input logic [1:0] sel,
		input logic [1:0] kind, input logic ep0, input logic dir_in,
		input logic first);
		logic r;
		r = 1'b0;
		case (kind)
			HS_ACK: r = 1'b1;
			HS_STALL: r = ep0 | ~dir_in;
			HS_NYET: r = ~ep0 & ~dir_in;
			HS_NAK: r = (sel == 2'h0) | (sel[1] & first);
			default: r = 1'b0;
		endcase
		return r;
	endfunction

	mirq_dev_st_type s_r;
	mirq_dev_st_type s_nxt;
	logic wr;
	logic rd;
	logic ep0;
	logic [1:0] sel;
	logic [4:0] hs_idx;
	logic [31:0] set_v;
	logic [31:0] clr_v;
	logic [7:0] falls;
	logic active;
	logic lvl;

	assign wr = ~bus.cs_n & ~bus.wr_n;
	assign rd = ~bus.cs_n & ~bus.rd_n;
	assign ep0 = hs_ep_i == 3'h0;
	assign hs_idx = HS_IDX_BASE + {1'b0, hs_ep_i, hs_dir_in_i};
	assign sel = ep0 ? s_r.icfg[IC_CTRL_LSB +: 2] :
		(hs_dir_in_i ? s_r.icfg[IC_IN_LSB +: 2] : s_r.icfg[IC_OUT_LSB +: 2]);

	always_comb begin
		s_nxt = s_r;
		falls = 8'h00;
		clr_v = 32'h0000_0000;
		set_v = {23'h000000, evt_src_i};
		// Handshake interrupts and first-NAK tracking
		if (hs_valid_i) begin
			if (hs_raise(sel, hs_kind_i, ep0, hs_dir_in_i,
				s_r.nak_first[hs_idx])) begin
				set_v = set_v | (32'h0000_0001 << hs_idx);
			end
			if (hs_kind_i == HS_ACK) begin
				s_nxt.nak_first[hs_idx] = 1'b1;
			end else if (hs_kind_i == HS_NAK) begin
				s_nxt.nak_first[hs_idx] = 1'b0;
			end
		end
		// Register reads, low byte only for byte registers
		if (rd) begin
			case (bus.addr)
				MODE_OFS: s_nxt.rdata = {8'h00, s_r.mode};
				ICFG_OFS: s_nxt.rdata = {8'h00, s_r.icfg};
				IEN_LO_OFS: s_nxt.rdata = s_r.ien[15:0];
				IEN_HI_OFS: s_nxt.rdata = s_r.ien[31:16];
				IRQ_LO_OFS: s_nxt.rdata = s_r.pend[15:0];
				IRQ_HI_OFS: s_nxt.rdata = s_r.pend[31:16];
				default: s_nxt.rdata = 16'h0000;
			endcase
		end
		// Register writes
		if (wr) begin
			case (bus.addr)
				MODE_OFS: begin
					falls = s_r.mode & ~bus.wdata[7:0];
					s_nxt.mode = bus.wdata[7:0];
				end
				ICFG_OFS: s_nxt.icfg = bus.wdata[7:0];
				IEN_LO_OFS: s_nxt.ien[15:0] = bus.wdata & IEN_WMASK[15:0];
				IEN_HI_OFS: s_nxt.ien[31:16] = bus.wdata & IEN_WMASK[31:16];
				IRQ_LO_OFS: clr_v[15:0] = bus.wdata;
				IRQ_HI_OFS: clr_v[31:16] = bus.wdata;
				default: ;
			endcase
		end
		// Set wins over a clear in the same cycle
		s_nxt.pend = (s_r.pend & ~clr_v) | set_v;
		// Pulse generation on each new enabled interrupt
		if (s_r.mode[MB_GIRQ] && |(set_v & s_r.ien & ~s_r.pend) &&
			s_r.icfg[IC_PULSE]) begin
			s_nxt.pcnt = 2'(IRQ_PULSE_CYC);
		end else if (s_r.pcnt != 2'h0) begin
			s_nxt.pcnt = s_r.pcnt - 2'h1;
		end
		// Upstream resume sequence
		case (s_r.res)
			RES_IDLE: ;
			RES_WAIT: begin
				if (s_r.tmr == TMR_W'(RES_DELAY_CYC - 1)) begin
					s_nxt.res = RES_DRIVE;
					s_nxt.tmr = '0;
					s_nxt.susp = 1'b0;
				end else begin
					s_nxt.tmr = s_r.tmr + 1'b1;
				end
			end
			RES_DRIVE: begin
				if (s_r.tmr == TMR_W'(RES_DRIVE_CYC - 1)) begin
					s_nxt.res = RES_IDLE;
					s_nxt.tmr = '0;
				end else begin
					s_nxt.tmr = s_r.tmr + 1'b1;
				end
			end
			default: s_nxt.res = RES_IDLE;
		endcase
		if (falls[MB_WAKEUP] ||
			(s_r.mode[MB_WAKE_CS] && s_r.susp && !bus.cs_n &&
			s_r.res == RES_IDLE)) begin
			s_nxt.res = RES_WAIT;
			s_nxt.tmr = '0;
		end
		// Suspend entry and exit
		if (falls[MB_SUSPEND]) begin
			s_nxt.susp = 1'b1;
		end else if (usb_resume_i) begin
			s_nxt.susp = 1'b0;
		end
		// Clock stop while suspended
		if (s_r.susp && !s_r.mode[MB_CLK_ON]) begin
			if (!s_r.clk_stop) begin
				if (s_r.ctmr == TMR_W'(CLK_STOP_CYC - 1)) begin
					s_nxt.clk_stop = 1'b1;
				end else begin
					s_nxt.ctmr = s_r.ctmr + 1'b1;
				end
			end
		end else begin
			s_nxt.clk_stop = 1'b0;
			s_nxt.ctmr = '0;
		end
		// Bus reset
		if (usb_bus_reset_i) begin
			s_nxt.mode = s_nxt.mode & MODE_BRST_KEEP;
			s_nxt.icfg = (s_nxt.icfg & ICFG_BRST_KEEP) | ICFG_BRST_SET;
			s_nxt.ien = s_nxt.ien & IEN_BRST_KEEP;
			s_nxt.susp = 1'b0;
			s_nxt.res = RES_IDLE;
			s_nxt.tmr = '0;
		end
		// Soft reset returns every register to its reset state
		if (falls[MB_SRESET]) begin
			s_nxt = DEV_RST;
		end
	end

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s_r <= DEV_RST;
		end else if (clk_en_i) begin
			s_r <= s_nxt;
		end
	end

	assign active = s_r.mode[MB_GIRQ] & |(s_r.pend & s_r.ien);
	assign lvl = s_r.icfg[IC_PULSE] ? (s_r.pcnt != 2'h0) : active;
	assign irq_o = s_r.icfg[IC_POL] ? lvl : ~lvl;
	assign suspended_o = s_r.susp;
	assign suspend_o = s_r.susp & s_r.mode[MB_POWER_OFF_IN_SLEEP];
	assign clk_stop_o = s_r.clk_stop;
	assign resume_drive_o = s_r.res == RES_DRIVE;
	assign pullup_resistor_pin_o = s_r.mode[MB_PULLUP];
	assign wake_req_o = s_r.mode[MB_WAKE_CS] & s_r.susp & ~bus.cs_n;
	assign bus.rdata = s_r.rdata;
endmodule

// *** core/mirq_host.sv ***
// Controller end: APB command registers driving the parallel register bus
`timescale 1ns/10ps
module mirq_host (
	// Clock, reset, enable
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	input wire logic clk_en_i,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Device bus
	mirq_if.host bus
);
	import mirq_pkg::*;

	typedef struct packed {
		mirq_hst_type st;
		logic cs_n;
		logic wr_n;
		logic rd_n;
		logic [7:0] target;
		logic [15:0] wbuf;
		logic [15:0] rbuf;
		logic rvalid;
	} mirq_host_st_type;

	localparam mirq_host_st_type HOST_RST = '{st: HST_IDLE, cs_n: 1'b1,
		wr_n: 1'b1, rd_n: 1'b1, default: '0};

	mirq_host_st_type s_r;
	mirq_host_st_type s_nxt;
	logic acc;
	logic mapped;

	assign acc = psel & penable;
	assign mapped = paddr == HC_TARGET_OFS || paddr == HC_WDATA_OFS ||
		paddr == HC_CMD_OFS || paddr == HC_STATUS_OFS ||
		paddr == HC_RDATA_OFS;

	always_comb begin
		s_nxt = s_r;
		case (s_r.st)
			HST_IDLE: ;
			HST_WR: begin
				s_nxt.st = HST_IDLE;
				s_nxt.cs_n = 1'b1;
				s_nxt.wr_n = 1'b1;
			end
			HST_RD: begin
				s_nxt.st = HST_CAP;
				s_nxt.cs_n = 1'b1;
				s_nxt.rd_n = 1'b1;
			end
			HST_CAP: begin
				s_nxt.st = HST_IDLE;
				s_nxt.rbuf = bus.rdata;
				s_nxt.rvalid = 1'b1;
			end
			default: s_nxt.st = HST_IDLE;
		endcase
		if (acc && pwrite) begin
			case (paddr)
				HC_TARGET_OFS: s_nxt.target = pwdata[7:0];
				HC_WDATA_OFS: s_nxt.wbuf = pwdata[15:0];
				HC_CMD_OFS: begin
					if (s_r.st == HST_IDLE && pwdata[HC_CMD_WR]) begin
						s_nxt.st = HST_WR;
						s_nxt.cs_n = 1'b0;
						s_nxt.wr_n = 1'b0;
					end else if (s_r.st == HST_IDLE && pwdata[HC_CMD_RD]) begin
						s_nxt.st = HST_RD;
						s_nxt.cs_n = 1'b0;
						s_nxt.rd_n = 1'b0;
						s_nxt.rvalid = 1'b0;
					end
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s_r <= HOST_RST;
		end else if (clk_en_i) begin
			s_r <= s_nxt;
		end
	end

	always_comb begin
		case (paddr)
			HC_TARGET_OFS: prdata = {24'h000000, s_r.target};
			HC_WDATA_OFS: prdata = {16'h0000, s_r.wbuf};
			HC_STATUS_OFS: prdata = {30'h00000000, s_r.rvalid,
				s_r.st != HST_IDLE};
			HC_RDATA_OFS: prdata = {16'h0000, s_r.rbuf};
			default: prdata = 32'h0000_0000;
		endcase
	end

	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	assign bus.cs_n = s_r.cs_n;
	assign bus.wr_n = s_r.wr_n;
	assign bus.rd_n = s_r.rd_n;
	assign bus.addr = s_r.target;
	assign bus.wdata = s_r.wbuf;
endmodule

// *** verification/mirq_properties.sv ***
// Protocol checks on the parallel bus between the two ends
`timescale 1ns/10ps
module mirq_properties (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	// Device bus
	input wire logic cs_n,
	input wire logic wr_n,
	input wire logic rd_n,
	input wire logic [7:0] addr,
	input wire logic [15:0] wdata,
	input wire logic [15:0] rdata
);
	import mirq_pkg::*;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!reset_n_i);
	wr_select_a: assert property (!wr_n |-> !cs_n && rd_n)
		else $error("write strobe outside select");
	rd_select_a: assert property (!rd_n |-> !cs_n && wr_n)
		else $error("read strobe outside select");
	wr_once_a: assert property (!wr_n |=> wr_n && cs_n)
		else $error("write strobe longer than one cycle");
	rd_once_a: assert property (!rd_n |=> rd_n ##1 rd_n)
		else $error("read strobes too close");
	sel_strobe_a: assert property ($fell(cs_n) |-> !wr_n || !rd_n)
		else $error("select without strobe");
	byte_hi_a: assert property (!rd_n && (addr == MODE_OFS ||
		addr == ICFG_OFS) |=> rdata[15:8] == 8'h00)
		else $error("upper byte of byte register not zero");
	unmap_zero_a: assert property (!rd_n && addr == 8'h20 |=>
		rdata == 16'h0000)
		else $error("unmapped read not zero");
	rdata_hold_a: assert property ($changed(rdata) |->
		$past(!rd_n || !wr_n))
		else $error("read data moved without access");
endmodule

// *** verification/mode_and_irq_config_regs_test.sv ***
// Self-checking bench for both ends of the configuration bank
`timescale 1ns/10ps
`define CHK(nm, e, a) begin n_compared++; if ((a) !== (e)) begin \
	error_cnt++; $display("[ERR] %s exp %h got %h", nm, e, a); end end
module mode_and_irq_config_regs_test;
	import mirq_pkg::*;
	logic sys_clk_i = 0, reset_n_i = 0, clk_en_i = 1, usb_bus_reset_i = 0;
	logic usb_resume_i = 0, hs_valid_i = 0, hs_dir_in_i = 0;
	logic psel = 0, penable = 0, pwrite = 0, pready, pslverr, serr, e;
	logic irq_o, suspended_o, suspend_o, clk_stop_o, resume_drive_o;
	logic pullup_resistor_pin_o, wake_req_o, wake_seen = 0;
	logic [1:0] hs_kind_i = 0, s;
	logic [2:0] hs_ep_i = 0;
	logic [8:0] evt_src_i = 0;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, q, v;
	logic [1:0] seqk [5] = '{HS_ACK, HS_NAK, HS_NAK, HS_STALL, HS_NYET};
	int error_cnt = 0, n_compared = 0, n;
	mirq_if bus_if();
	mirq_dev #(.CLK_STOP_CYC(20), .RES_DELAY_CYC(10), .RES_DRIVE_CYC(15))
		i_mirq_dev (.sys_clk_i, .reset_n_i, .clk_en_i, .bus(bus_if.dev),
		.usb_bus_reset_i, .usb_resume_i, .hs_valid_i, .hs_kind_i,
		.hs_dir_in_i, .hs_ep_i, .evt_src_i, .irq_o, .suspended_o,
		.suspend_o, .clk_stop_o, .resume_drive_o, .pullup_resistor_pin_o,
		.wake_req_o);
	mirq_host i_mirq_host (.sys_clk_i, .reset_n_i, .clk_en_i, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.bus(bus_if.host));
	mirq_properties i_mirq_properties (.sys_clk_i, .reset_n_i,
		.cs_n(bus_if.cs_n), .wr_n(bus_if.wr_n), .rd_n(bus_if.rd_n),
		.addr(bus_if.addr), .wdata(bus_if.wdata), .rdata(bus_if.rdata));
	always #10 sys_clk_i = ~sys_clk_i;
	// Sticky record of any wake request seen at a clock edge
	always @(posedge sys_clk_i) begin
		if (wake_req_o === 1'b1)
			wake_seen <= 1'b1;
	end
	task wrap_up;
		$display("compared %0d errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task fail_out;
		error_cnt++;
		wrap_up();
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk_i);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk_i);
			n++;
		end while (pready !== 1'b1 && n < 20);
		q = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20)
			fail_out();
		@(posedge sys_clk_i);
	endtask
	// Poll status until the chosen bit shows the wanted value
	task wait_st(input int b, input logic w);
		int k;
		k = 0;
		do begin
			apb(1'b0, HC_STATUS_OFS, 0);
			k++;
		end while (q[b] !== w && k < 20);
		if (k >= 20)
			fail_out();
	endtask
	task dwr(input logic [7:0] a, input logic [15:0] d);
		apb(1'b1, HC_TARGET_OFS, {24'h0, a});
		apb(1'b1, HC_WDATA_OFS, {16'h0, d});
		apb(1'b1, HC_CMD_OFS, 32'h1);
		wait_st(0, 1'b0);
	endtask
	task drd(input logic [7:0] a);
		apb(1'b1, HC_TARGET_OFS, {24'h0, a});
		apb(1'b1, HC_CMD_OFS, 32'h2);
		wait_st(1, 1'b1);
		apb(1'b0, HC_RDATA_OFS, 0);
	endtask
	task hs(input logic [1:0] k, input logic [2:0] ep, input logic din);
		hs_valid_i <= 1'b1;
		hs_kind_i <= k;
		hs_ep_i <= ep;
		hs_dir_in_i <= din;
		@(posedge sys_clk_i);
		hs_valid_i <= 1'b0;
		repeat (2) @(posedge sys_clk_i);
	endtask
	task clr_pend;
		dwr(IRQ_LO_OFS, 16'hFFFF);
		dwr(IRQ_HI_OFS, 16'hFFFF);
	endtask
	task wait_drv(input logic w);
		n = 0;
		while (resume_drive_o !== w && n < 40) begin
			@(posedge sys_clk_i);
			n++;
		end
		if (n >= 40)
			fail_out();
	endtask
	function automatic logic hit(input int c, input logic [1:0] s,
		input logic [1:0] k, input logic f);
		case (k)
			HS_ACK: hit = 1'b1;
			HS_STALL: hit = (c != 1);
			HS_NAK: hit = s[1] ? f : !s[0];
			default: hit = (c == 2);
		endcase
	endfunction
	initial begin
		void'($urandom(32'h860d));
		repeat (16) @(posedge sys_clk_i);
		reset_n_i <= 1'b1;
		@(posedge sys_clk_i);
		drd(MODE_OFS);
		`CHK("mode", 16'h0000, q[15:0])
		drd(ICFG_OFS);
		`CHK("icfg", 16'h00FC, q[15:0])
		`CHK("irq_o", 1'b1, irq_o)
		for (int i = 0; i < 4; i++) begin
			v = $urandom;
			dwr(MODE_OFS, {v[15:8], 4'h0, v[3:0]});
			drd(MODE_OFS);
			`CHK("mode", {12'h0, v[3:0]}, q[15:0])
			`CHK("pullup", v[0], pullup_resistor_pin_o)
			dwr(ICFG_OFS, v[31:16]);
			drd(ICFG_OFS);
			`CHK("icfg", {8'h0, v[23:16]}, q[15:0])
		end
		dwr(IEN_LO_OFS, 16'hFFFF);
		dwr(MODE_OFS, 16'h000F);
		dwr(ICFG_OFS, v[15:0]);
		usb_bus_reset_i <= 1'b1;
		@(posedge sys_clk_i);
		usb_bus_reset_i <= 1'b0;
		@(posedge sys_clk_i);
		drd(MODE_OFS);
		`CHK("mode", 16'h000B, q[15:0])
		drd(ICFG_OFS);
		`CHK("icfg", {10'h3F, v[1:0]}, q[15:0])
		drd(IEN_LO_OFS);
		`CHK("enable", 16'h0001, q[15:0])
		for (int a = 0; a < 2; a++) begin
			dwr(MODE_OFS, {8'h0, a[0], 7'h22});
			`CHK("suspended", 1'b0, suspended_o)
			dwr(MODE_OFS, {8'h0, a[0], 7'h02});
			`CHK("suspended", 1'b1, suspended_o)
			`CHK("suspend", 1'b1, suspend_o)
			repeat (30) @(posedge sys_clk_i);
			`CHK("clk_stop", !a[0], clk_stop_o)
			usb_resume_i <= 1'b1;
			@(posedge sys_clk_i);
			usb_resume_i <= 1'b0;
			@(posedge sys_clk_i);
		end
		dwr(MODE_OFS, 16'h0040);
		dwr(MODE_OFS, 16'h0000);
		wait_drv(1'b1);
		// 10-cycle delay less the two edges of the status poll
		`CHK("resume_delay", 8, n)
		wait_drv(1'b0);
		`CHK("resume_len", 15, n)
		// Select low in suspend starts the resume sequence
		dwr(MODE_OFS, 16'h0024);
		dwr(MODE_OFS, 16'h0004);
		`CHK("wake_seen", 1'b0, wake_seen)
		`CHK("suspended", 1'b1, suspended_o)
		drd(MODE_OFS);
		`CHK("mode", 16'h0004, q[15:0])
		wait_drv(1'b1);
		`CHK("wake_seen", 1'b1, wake_seen)
		`CHK("suspended", 1'b0, suspended_o)
		wait_drv(1'b0);
		`CHK("resume_len", 15, n)
		dwr(IEN_LO_OFS, 16'hFFFF);
		dwr(IEN_HI_OFS, 16'hFFFF);
		dwr(MODE_OFS, 16'h0008);
		clr_pend();
		for (int c = 0; c < 3; c++)
			for (int m = 0; m < 3; m++) begin
				s = (m == 2) ? {1'b1, 1'($urandom)} : 2'(m);
				v[2:0] = (c == 0) ? 3'h0 : 3'($urandom_range(7, 1));
				v[3] = (c == 1) || (c == 0 && 1'($urandom));
				dwr(ICFG_OFS, {8'h0, s, s, s, 2'b00});
				for (int i = 0; i < 5; i++) begin
					e = hit(c, s, seqk[i], i == 1);
					hs(seqk[i], v[2:0], v[3]);
					`CHK("irq_o", !e, irq_o)
					clr_pend();
				end
			end
		dwr(MODE_OFS, 16'h0000);
		hs(HS_ACK, 3'h0, 1'b0);
		`CHK("irq_o", 1'b1, irq_o)
		clr_pend();
		dwr(ICFG_OFS, 16'h0001);
		dwr(MODE_OFS, 16'h0008);
		`CHK("irq_o", 1'b0, irq_o)
		hs(HS_ACK, 3'h0, 1'b0);
		`CHK("irq_o", 1'b1, irq_o)
		clr_pend();
		dwr(ICFG_OFS, 16'h0003);
		hs_valid_i <= 1'b1;
		hs_kind_i <= HS_ACK;
		n = 0;
		repeat (8) begin
			@(posedge sys_clk_i);
			hs_valid_i <= 1'b0;
			n += int'(irq_o === 1'b1);
		end
		`CHK("pulse_len", IRQ_PULSE_CYC, n)
		dwr(ICFG_OFS, 16'h0001);
		dwr(MODE_OFS, 16'h0010);
		dwr(MODE_OFS, 16'h0000);
		drd(ICFG_OFS);
		`CHK("icfg", 16'h00FC, q[15:0])
		// Bus reset while the clock enable is low must not land
		dwr(MODE_OFS, 16'h0080);
		clk_en_i <= 1'b0;
		usb_bus_reset_i <= 1'b1;
		repeat (2) @(posedge sys_clk_i);
		usb_bus_reset_i <= 1'b0;
		clk_en_i <= 1'b1;
		@(posedge sys_clk_i);
		drd(MODE_OFS);
		`CHK("frozen", 16'h0080, q[15:0])
		drd(8'h20);
		`CHK("unmapped", 16'h0000, q[15:0])
		apb(1'b0, 8'h20, 0);
		`CHK("pslverr", 1'b1, serr)
		wrap_up();
	end
endmodule
